/* File: cgm_pkg.sv */
// Package with register map, field layout, reset values and carrier types of the PLL configuration block.
// Behaviour
// RULE1 - Multiplier low byte writable only while PLL off
// RULE2 - Zero multiplier acts as multiplier one
// RULE3 - Multiplier low byte resets to sixty-four
// RULE4 - Software reprograms multiplier, keeps VCO below limit
// RULE5 - VCO range byte locked while PLL on
// RULE6 - Zero VCO range disables PLL, forbids VCO select
// RULE7 - VCO range byte resets to sixty-four
// RULE8 - Reference divider writable only while PLL off
// RULE9 - Zero reference divider acts as one
// RULE10 - Reference divider resets to divide by one
// RULE11 - Upper reference divider bits read zero
// RULE12 - Lock change sets flag in auto mode
// RULE13 - Manual mode suppresses interrupt, flag reads zero
// RULE14 - Software checks lock after each interrupt
// RULE15 - VCO select allowed without lock
// RULE16 - Wait mode leaves clock generator unchanged
// RULE17 - Stop without oscillator kills all outputs
// RULE18 - Stop clears VCO select, stays clear after
// RULE19 - Stop with oscillator enable keeps oscillator
// RULE20 - Break without clear enable protects flag
// RULE21 - Break with clear enable clears stick
// RULE22 - Control register read clears interrupt flag
// RULE23 - Base clock halves source, static while switching
// RULE24 - Select needs PLL on; PLL stays while selected
// RULE25 - Feedback value is high nibble over low byte
package cgm_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CGM_OFS_CTRL  = 8'h00;
    localparam logic [7:0] CGM_OFS_BW    = 8'h04;
    localparam logic [7:0] CGM_OFS_MULH  = 8'h08;
    localparam logic [7:0] CGM_OFS_MULL  = 8'h0c;
    localparam logic [7:0] CGM_OFS_VRS   = 8'h10;
    localparam logic [7:0] CGM_OFS_RDIV  = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CGM_CTRL_IE   = 7;
    localparam int CGM_CTRL_FLAG = 6;
    localparam int CGM_CTRL_EN   = 5;
    localparam int CGM_CTRL_BCS  = 4;
    localparam int CGM_CTRL_VPR  = 2;
    localparam int CGM_CTRL_PRE  = 0;
    localparam int CGM_BW_AUTO   = 7;
    localparam int CGM_BW_LOCK   = 6;
    localparam int CGM_BW_ACQ    = 5;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic       CGM_RST_EN   = 1'b1;
    localparam logic [3:0] CGM_RST_MULH = 4'h0;
    localparam logic [7:0] CGM_RST_MULL = 8'h40;
    localparam logic [7:0] CGM_RST_VRS  = 8'h40;
    localparam logic [3:0] CGM_RST_RDIV = 4'h1;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam logic [1:0] CGM_SWITCH_EDGES = 2'h3;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } cgm_avs_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } cgm_avs_rsp_t;

    typedef struct packed {
        logic stop_mode;
        logic break_state;
        logic break_clear_enable;
        logic osc_run_in_stop;
        logic pll_lock;
        logic crystal_clock;
        logic vco_clock;
    } cgm_sys_t;

    typedef struct packed {
        logic        pll_power;
        logic        acq_manual;
        logic [1:0]  vco_power_range;
        logic [1:0]  prescaler;
        logic [11:0] feedback_div;
        logic [7:0]  vco_range_bits;
        logic [3:0]  reference_divider_bits;
    } cgm_pll_cfg_t;

    typedef struct packed {
        logic osc_enable;
        logic crystal_clock_out;
        logic base_clock_out;
        logic clockgen_irq;
    } cgm_clk_out_t;

endpackage : cgm_pkg

/* File: cgm_pll_config.sv */
// PLL divider configuration, clock select, lock interrupt and low-power handling.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module cgm_pll_config (
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    input  wire cgm_pkg::cgm_avs_req_t avs_req,
    output logic                       avs_waitrequest,
    output logic [31:0]                avs_readdata,
    input  wire cgm_pkg::cgm_sys_t     sys,
    output cgm_pkg::cgm_pll_cfg_t      pll_cfg,
    output cgm_pkg::cgm_clk_out_t      clk_out
);
    import cgm_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic         wait_n;
        logic         busy;
        logic [31:0]  rdata;
        logic         irq_enable;
        logic         irq_flag;
        logic         pll_enable;
        logic         base_clock_select;
        logic [1:0]   vpr;
        logic [1:0]   pre;
        logic         auto_bw;
        logic         acq;
        logic [3:0]   mul_high;
        logic [7:0]   multiplier_low_bits;
        logic [7:0]   vco_range_bits;
        logic [3:0]   reference_divider_bits;
        logic         lock_prev;
        logic         stop_prev;
        logic         xclk_prev;
        logic         vclk_prev;
        logic         sel_active;
        logic [1:0]   xcnt;
        logic [1:0]   vcnt;
        cgm_pll_cfg_t cfg;
        cgm_clk_out_t clk;
    } cgm_state_t;

    cgm_state_t s_q;
    cgm_state_t s_d;
    logic       rst_meta_q;
    logic       rst_sync_b_q;

    // ****************************************
    // Reset release
    // ****************************************
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q   <= 1'b0;
            rst_sync_b_q <= 1'b0;
        end
        else
        begin
            rst_meta_q   <= 1'b1;
            rst_sync_b_q <= rst_meta_q;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic        taken;
        logic        access;
        logic        wr_ok;
        logic        rd_ctrl;
        logic        prot;
        logic        lock_chg;
        logic        stop_entry;
        logic        osc_dead;
        logic        xedge;
        logic        vedge;
        logic        vrs_zero;
        logic [7:0]  wb;
        logic [7:0]  rb;
        logic [11:0] fb;
        logic [3:0]  rd;

        s_d        = s_q;
        access     = avs_req.read || avs_req.write;
        taken      = access && s_q.wait_n;
        wr_ok      = taken && avs_req.write && avs_req.byteenable[0];
        rd_ctrl    = taken && avs_req.read && (avs_req.address == CGM_OFS_CTRL);
        wb         = avs_req.writedata[7:0];
        rb         = 8'h00;
        prot       = sys.break_state && !sys.break_clear_enable;
        lock_chg   = sys.pll_lock != s_q.lock_prev;
        stop_entry = sys.stop_mode && !s_q.stop_prev;
        osc_dead   = sys.stop_mode && !sys.osc_run_in_stop;
        xedge      = sys.crystal_clock && !s_q.xclk_prev;
        vedge      = sys.vco_clock && !s_q.vclk_prev;
        vrs_zero   = s_q.vco_range_bits == 8'h00;

        // Bus slave: one wait cycle, then the answer stands for one cycle.
        s_d.wait_n = access && !s_q.wait_n;
        s_d.busy   = !(access && !s_q.wait_n);
        if (access && !s_q.wait_n)
        begin
            unique case (avs_req.address)
                CGM_OFS_CTRL:
                begin
                    rb[CGM_CTRL_IE]           = s_q.irq_enable;
                    rb[CGM_CTRL_FLAG]         = s_q.irq_flag && s_q.auto_bw;                  // [RULE13]
                    rb[CGM_CTRL_EN]           = s_q.pll_enable;
                    rb[CGM_CTRL_BCS]          = s_q.base_clock_select;
                    rb[CGM_CTRL_VPR +: 2]     = s_q.vpr;
                    rb[CGM_CTRL_PRE +: 2]     = s_q.pre;
                end
                CGM_OFS_BW:
                begin
                    rb[CGM_BW_AUTO]           = s_q.auto_bw;
                    rb[CGM_BW_LOCK]           = s_q.auto_bw && sys.pll_lock;
                    rb[CGM_BW_ACQ]            = s_q.auto_bw ? sys.pll_lock : s_q.acq;
                end
                CGM_OFS_MULH: rb = {4'h0, s_q.mul_high};
                CGM_OFS_MULL: rb = s_q.multiplier_low_bits;
                CGM_OFS_VRS:  rb = s_q.vco_range_bits;
                CGM_OFS_RDIV: rb = {4'h0, s_q.reference_divider_bits};                     // [RULE11]
                default:      rb = 8'h00;
            endcase
        end
        s_d.rdata = {24'h000000, rb};

        // Register writes take effect on the accepting edge only.
        if (wr_ok)
        begin
            unique case (avs_req.address)
                CGM_OFS_CTRL:
                begin
                    s_d.irq_enable = wb[CGM_CTRL_IE] && s_q.auto_bw;
                    s_d.pll_enable = wb[CGM_CTRL_EN] || s_q.base_clock_select;              // [RULE24]
                    // Lock state is not consulted, so the VCO may be selected early.
                    s_d.base_clock_select = wb[CGM_CTRL_BCS] && s_q.pll_enable && !vrs_zero; // [RULE24] [RULE6] [RULE15]
                    if (!s_q.pll_enable)
                    begin
                        s_d.vpr = wb[CGM_CTRL_VPR +: 2];
                        s_d.pre = wb[CGM_CTRL_PRE +: 2];
                    end
                end
                CGM_OFS_BW:
                begin
                    s_d.auto_bw = wb[CGM_BW_AUTO];
                    if (!s_q.auto_bw)
                    begin
                        s_d.acq = wb[CGM_BW_ACQ];
                    end
                end
                CGM_OFS_MULH:
                begin
                    if (!s_q.pll_enable)
                    begin
                        s_d.mul_high = wb[3:0];
                    end
                end
                CGM_OFS_MULL:
                begin
                    if (!s_q.pll_enable)
                    begin
                        s_d.multiplier_low_bits = wb;                                       // [RULE1]
                    end
                end
                CGM_OFS_VRS:
                begin
                    if (!s_q.pll_enable)
                    begin
                        s_d.vco_range_bits = wb;                                            // [RULE5]
                    end
                end
                CGM_OFS_RDIV:
                begin
                    if (!s_q.pll_enable)
                    begin
                        s_d.reference_divider_bits = wb[3:0];                               // [RULE8] [RULE11]
                    end
                end
                default:
                begin
                    s_d.auto_bw = s_q.auto_bw;
                end
            endcase
        end

        // Only a flag that the reader actually saw is cleared, so a change landing during
        // the wait cycle survives; a set in the clearing cycle also wins.
        if (rd_ctrl && !prot && s_q.rdata[CGM_CTRL_FLAG])
        begin
            s_d.irq_flag = 1'b0;                                                            // [RULE22] [RULE20] [RULE21]
        end
        if (s_q.auto_bw && lock_chg)
        begin
            s_d.irq_flag = 1'b1;                                                            // [RULE12]
        end
        if (!s_d.auto_bw)
        begin
            s_d.irq_enable = 1'b0;                                                          // [RULE13]
        end
        s_d.lock_prev = sys.pll_lock;

        // A zero range byte forces the VCO off the base clock; the wait mode has no path here.
        if (vrs_zero || !s_d.pll_enable)
        begin
            s_d.base_clock_select = 1'b0;                                                   // [RULE6] [RULE16]
        end
        if (stop_entry)
        begin
            s_d.base_clock_select = 1'b0;                                                   // [RULE18]
        end
        s_d.stop_prev = sys.stop_mode;

        // Base clock divider and glitch-free source change.
        s_d.xclk_prev = sys.crystal_clock;
        s_d.vclk_prev = sys.vco_clock;
        if (s_q.sel_active != s_q.base_clock_select)
        begin
            if (xedge && s_q.xcnt != CGM_SWITCH_EDGES)
            begin
                s_d.xcnt = s_q.xcnt + 2'h1;
            end
            if (vedge && s_q.vcnt != CGM_SWITCH_EDGES)
            begin
                s_d.vcnt = s_q.vcnt + 2'h1;
            end
            // A stopped VCO never delivers edges, so its count is waived when it is off.
            if (s_q.xcnt == CGM_SWITCH_EDGES && (s_q.vcnt == CGM_SWITCH_EDGES || !s_q.cfg.pll_power))
            begin
                s_d.sel_active = s_q.base_clock_select;                                     // [RULE23]
                s_d.xcnt       = 2'h0;
                s_d.vcnt       = 2'h0;
            end
        end
        else
        begin
            // Counts left from an aborted switch would shorten the next one.
            s_d.xcnt = 2'h0;
            s_d.vcnt = 2'h0;
            if (s_q.sel_active ? vedge : xedge)
            begin
                s_d.clk.base_clock_out = !s_q.clk.base_clock_out;                           // [RULE23]
            end
        end

        // Outputs toward the analog loop and the system.
        fb = {s_q.mul_high, s_q.multiplier_low_bits};                                       // [RULE25]
        rd = s_q.reference_divider_bits;
        s_d.cfg.feedback_div           = (fb == 12'h000) ? 12'h001 : fb;                    // [RULE2]
        s_d.cfg.reference_divider_bits = (rd == 4'h0) ? 4'h1 : rd;                          // [RULE9]
        s_d.cfg.vco_range_bits         = s_q.vco_range_bits;
        s_d.cfg.vco_power_range        = s_q.vpr;
        s_d.cfg.prescaler              = s_q.pre;
        s_d.cfg.acq_manual             = s_q.acq;
        s_d.cfg.pll_power              = s_q.pll_enable && !vrs_zero && !sys.stop_mode;     // [RULE6] [RULE19]
        s_d.clk.osc_enable             = !osc_dead;                                         // [RULE19]
        s_d.clk.crystal_clock_out      = sys.crystal_clock && !osc_dead;
        s_d.clk.clockgen_irq           = s_q.irq_flag && s_q.irq_enable && s_q.auto_bw && !osc_dead; // [RULE12]
        if (osc_dead)
        begin
            s_d.clk.base_clock_out = 1'b0;                                                  // [RULE17]
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk or negedge rst_sync_b_q)
    begin
        if (!rst_sync_b_q)
        begin
            s_q                        <= '0;
            s_q.busy                   <= 1'b1;
            s_q.pll_enable             <= CGM_RST_EN;
            s_q.mul_high               <= CGM_RST_MULH;
            s_q.multiplier_low_bits    <= CGM_RST_MULL;                                     // [RULE3]
            s_q.vco_range_bits         <= CGM_RST_VRS;                                      // [RULE7]
            s_q.reference_divider_bits <= CGM_RST_RDIV;                                     // [RULE10]
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest = s_q.busy;
    assign avs_readdata    = s_q.rdata;
    assign pll_cfg         = s_q.cfg;
    assign clk_out         = s_q.clk;

endmodule : cgm_pll_config

/* File: cgm_pll_config_assertions.sv */
// Concurrent checks on the ports of the PLL configuration block.
`timescale 1ns/1ps
module cgm_pll_config_assertions (
    input wire logic                  mclk,
    input wire logic                  rst_b,
    input wire cgm_pkg::cgm_avs_req_t avs_req,
    input wire logic                  avs_waitrequest,
    input wire logic [31:0]           avs_readdata,
    input wire cgm_pkg::cgm_sys_t     sys,
    input wire cgm_pkg::cgm_pll_cfg_t pll_cfg,
    input wire cgm_pkg::cgm_clk_out_t clk_out
);
    import cgm_pkg::*;
    // ********
    // Helpers
    // ********
    // Outputs are zero for a few edges after release, so checks wait for this.
    logic [2:0] up_q;
    logic       rdy;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            up_q <= 3'h0;
        else if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
    end
    assign rdy = (up_q > 3'h4);
    sequence s_stop(logic k);
        (rdy && sys.stop_mode && sys.osc_run_in_stop == k)[*3];
    endsequence
    sequence s_locked(logic [7:0] a);
        pll_cfg.pll_power && avs_req.write && !avs_waitrequest && avs_req.address == a;
    endsequence
    // ********
    // Properties
    // ********
    property p_fb_one;
        rdy |-> pll_cfg.feedback_div != 12'h000;
    endproperty
    a_fb_one : assert property (p_fb_one) else $error("feedback value zero");
    property p_rd_one;
        rdy |-> pll_cfg.reference_divider_bits != 4'h0;
    endproperty
    a_rd_one : assert property (p_rd_one) else $error("reference divider zero");
    property p_rd_hi;
        avs_req.read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0 &&
            (avs_req.address != CGM_OFS_RDIV || avs_readdata[7:4] == 4'h0);
    endproperty
    a_rd_hi : assert property (p_rd_hi) else $error("unused read bits set");
    property p_pwr_off;
        rdy && (pll_cfg.vco_range_bits == 8'h00 || sys.stop_mode) |-> ##[1:2] !pll_cfg.pll_power;
    endproperty
    a_pwr_off : assert property (p_pwr_off) else $error("loop powered");
    property p_stop_off;
        s_stop(1'b0) |-> !clk_out.osc_enable && !clk_out.crystal_clock_out && !clk_out.clockgen_irq &&
            !clk_out.base_clock_out;
    endproperty
    a_stop_off : assert property (p_stop_off) else $error("outputs live in stop");
    property p_stop_osc;
        s_stop(1'b1) |-> clk_out.osc_enable;
    endproperty
    a_stop_osc : assert property (p_stop_osc) else $error("oscillator off in stop");
    property p_wait;
        rdy && $rose(avs_req.read || avs_req.write) |-> avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait : assert property (p_wait) else $error("bus answer timing");
    property p_lock_mul;
        s_locked(CGM_OFS_MULL) |-> ##1 $stable(pll_cfg.feedback_div)[*2];
    endproperty
    a_lock_mul : assert property (p_lock_mul) else $error("multiplier changed");
    property p_lock_vrs;
        s_locked(CGM_OFS_VRS) |-> ##1 $stable(pll_cfg.vco_range_bits)[*2];
    endproperty
    a_lock_vrs : assert property (p_lock_vrs) else $error("range changed");
    property p_lock_rdv;
        s_locked(CGM_OFS_RDIV) |-> ##1 $stable(pll_cfg.reference_divider_bits)[*2];
    endproperty
    a_lock_rdv : assert property (p_lock_rdv) else $error("divider changed");
endmodule : cgm_pll_config_assertions
bind cgm_pll_config cgm_pll_config_assertions cgm_pll_config_assertions_i (.mclk(mclk), .rst_b(rst_b),
    .avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .sys(sys),
    .pll_cfg(pll_cfg), .clk_out(clk_out));

/* File: tb_cgm_pll_config.sv */
// Register-level testbench of the PLL configuration block.
`timescale 1ns/1ps
module tb_cgm_pll_config;
    import cgm_pkg::*;
    logic          mclk;
    logic          rst_b;
    cgm_avs_req_t  req;
    logic          wr;
    logic [31:0]   rdat;
    cgm_sys_t      sys;
    cgm_pll_cfg_t  cfg;
    cgm_clk_out_t  co;
    logic [2:0]    tk;
    logic [31:0]   d;
    int            err_count;
    int            cmp_count;
    int            cyc;
    cgm_pll_config cgm_pll_config_i (.mclk(mclk), .rst_b(rst_b), .avs_req(req), .avs_waitrequest(wr),
        .avs_readdata(rdat), .sys(sys), .pll_cfg(cfg), .clk_out(co));
    // ********
    // Clocks
    // ********
    // Source clocks run slower than half of mclk, as the sampling inputs demand.
    always #10 mclk = ~mclk;
    always @(posedge mclk)
    begin
        tk <= tk + 3'h1;
        sys.crystal_clock <= tk[2];
        sys.vco_clock <= tk[1];
        cyc++;
        if (cyc == 6000)
        begin
            err_count++;
            give_verdict();
        end
    end
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        int k;
        @(posedge mclk);
        req.read <= !w;
        req.write <= w;
        req.address <= a;
        req.writedata <= {24'h0, v};
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (wr !== 1'b0);
        chk(32'(k), 32'h2);
        d = rdat;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic wr8(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask : wr8
    task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(d & {24'h0, m}, {24'h0, e});
    endtask : rdm
    // One base clock toggle per period of the selected source.
    task automatic tog(input int e);
        logic p;
        int   t;
        p = co.base_clock_out;
        t = 0;
        repeat (64)
        begin
            @(posedge mclk);
            if (co.base_clock_out !== p)
                t++;
            p = co.base_clock_out;
        end
        chk(32'(t), 32'(e));
    endtask : tog
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // ********
    // Tests
    // ********
    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        req.byteenable = 4'h1;
        sys = '0;
        tk = 3'h0;
        err_count = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        rdm(CGM_OFS_MULL, 8'hff, 8'h40);
        rdm(CGM_OFS_VRS, 8'hff, 8'h40);
        rdm(CGM_OFS_RDIV, 8'hff, 8'h01);
        rdm(CGM_OFS_CTRL, 8'h20, 8'h20);
        chk(32'(cfg.feedback_div), 32'h040);
        rdm(8'h18, 8'hff, 8'h00);
        $display("T1 reset values done");
        wr8(CGM_OFS_MULL, 8'h12);
        wr8(CGM_OFS_VRS, 8'h33);
        wr8(CGM_OFS_RDIV, 8'h05);
        wr8(CGM_OFS_CTRL, 8'h2f);
        rdm(CGM_OFS_CTRL, 8'h0f, 8'h00);
        rdm(CGM_OFS_MULL, 8'hff, 8'h40);
        rdm(CGM_OFS_VRS, 8'hff, 8'h40);
        rdm(CGM_OFS_RDIV, 8'hff, 8'h01);
        $display("T2 locked writes done");
        wr8(CGM_OFS_CTRL, 8'h00);
        wr8(CGM_OFS_CTRL, 8'h05);
        rdm(CGM_OFS_CTRL, 8'h0f, 8'h05);
        chk(32'({cfg.vco_power_range, cfg.prescaler}), 32'h5);
        wr8(CGM_OFS_MULH, 8'h00);
        wr8(CGM_OFS_MULL, 8'h00);
        rdm(CGM_OFS_MULL, 8'hff, 8'h00);
        chk(32'(cfg.feedback_div), 32'h001);
        wr8(CGM_OFS_MULH, 8'h03);
        wr8(CGM_OFS_MULL, 8'h25);
        rdm(CGM_OFS_MULL, 8'hff, 8'h25);
        chk(32'(cfg.feedback_div), 32'h325);
        wr8(CGM_OFS_RDIV, 8'hff);
        rdm(CGM_OFS_RDIV, 8'hff, 8'h0f);
        wr8(CGM_OFS_RDIV, 8'h00);
        rdm(CGM_OFS_RDIV, 8'hff, 8'h00);
        chk(32'(cfg.reference_divider_bits), 32'h1);
        wr8(CGM_OFS_RDIV, 8'h01);
        wr8(CGM_OFS_VRS, 8'h5a);
        rdm(CGM_OFS_VRS, 8'hff, 8'h5a);
        chk(32'(cfg.vco_range_bits), 32'h5a);
        $display("T3 open writes done");
        wr8(CGM_OFS_CTRL, 8'h10);
        rdm(CGM_OFS_CTRL, 8'h30, 8'h00);
        wr8(CGM_OFS_CTRL, 8'h20);
        wr8(CGM_OFS_CTRL, 8'h30);
        rdm(CGM_OFS_CTRL, 8'h30, 8'h30);
        wr8(CGM_OFS_CTRL, 8'h10);
        rdm(CGM_OFS_CTRL, 8'h30, 8'h30);
        wr8(CGM_OFS_CTRL, 8'h20);
        wr8(CGM_OFS_CTRL, 8'h00);
        wr8(CGM_OFS_VRS, 8'h00);
        wr8(CGM_OFS_CTRL, 8'h20);
        wr8(CGM_OFS_CTRL, 8'h30);
        rdm(CGM_OFS_CTRL, 8'h30, 8'h20);
        chk(32'(cfg.pll_power), 32'h0);
        wr8(CGM_OFS_CTRL, 8'h00);
        wr8(CGM_OFS_VRS, 8'h40);
        wr8(CGM_OFS_CTRL, 8'h20);
        tog(64 / 8);
        wr8(CGM_OFS_CTRL, 8'h30);
        repeat (40) @(posedge mclk);
        tog(64 / 4);
        $display("T4 clock select done");
        wr8(CGM_OFS_BW, 8'h20);
        sys.pll_lock <= 1'b1;
        repeat (4) @(posedge mclk);
        rdm(CGM_OFS_CTRL, 8'h40, 8'h00);
        chk(32'(co.clockgen_irq), 32'h0);
        chk(32'(cfg.acq_manual), 32'h1);
        wr8(CGM_OFS_BW, 8'h80);
        wr8(CGM_OFS_CTRL, 8'hb0);
        sys.pll_lock <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(32'(co.clockgen_irq), 32'h1);
        rdm(CGM_OFS_CTRL, 8'h40, 8'h40);
        rdm(CGM_OFS_BW, 8'h40, 8'h00);
        rdm(CGM_OFS_CTRL, 8'h40, 8'h00);
        chk(32'(co.clockgen_irq), 32'h0);
        wr8(CGM_OFS_CTRL, 8'h30);
        sys.pll_lock <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(co.clockgen_irq), 32'h0);
        rdm(CGM_OFS_CTRL, 8'h40, 8'h40);
        sys.break_state <= 1'b1;
        sys.pll_lock <= 1'b0;
        repeat (4) @(posedge mclk);
        rdm(CGM_OFS_CTRL, 8'h40, 8'h40);
        rdm(CGM_OFS_CTRL, 8'h40, 8'h40);
        sys.break_clear_enable <= 1'b1;
        rdm(CGM_OFS_CTRL, 8'h40, 8'h40);
        sys.break_state <= 1'b0;
        sys.break_clear_enable <= 1'b0;
        rdm(CGM_OFS_CTRL, 8'h40, 8'h00);
        sys.pll_lock <= 1'b1;
        repeat (4) @(posedge mclk);
        wr8(CGM_OFS_BW, 8'h00);
        rdm(CGM_OFS_CTRL, 8'hc0, 8'h00);
        $display("T5 lock flag done");
        sys.stop_mode <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(32'({co.osc_enable, co.crystal_clock_out, co.clockgen_irq, co.base_clock_out}), 32'h0);
        chk(32'(cfg.pll_power), 32'h0);
        sys.stop_mode <= 1'b0;
        repeat (4) @(posedge mclk);
        rdm(CGM_OFS_CTRL, 8'h30, 8'h20);
        repeat (40) @(posedge mclk);
        tog(64 / 8);
        sys.osc_run_in_stop <= 1'b1;
        sys.stop_mode <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(32'(co.osc_enable), 32'h1);
        chk(32'(cfg.pll_power), 32'h0);
        sys.stop_mode <= 1'b0;
        $display("T6 stop mode done");
        give_verdict();
    end
endmodule : tb_cgm_pll_config
